/* verilog/asc_pkg.sv */
package asc_pkg;
    // result word width and sampling clock
    localparam int DATA_W = 24;
    localparam int CLK_PERIOD_NS = 50;
    // settling time after a start covers two output periods
    localparam int SETTLE_TIME_US = 120400;
    localparam int SETTLE_PERIODS = 2;
    localparam int SETTLE_CYC = SETTLE_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int PERIOD_CYC = SETTLE_CYC / SETTLE_PERIODS;
    // consecutive ones on the data input that reset the interface
    localparam logic [5:0] IFRST_ONES = 6'h20;
    // serial register power-on values; id value is arbitrary
    localparam logic [7:0] MODE_RST = 8'h02;
    localparam logic [3:0] STATUS_ID = 4'h5;
    // command byte fields
    localparam int CMD_WEN = 7;
    localparam int CMD_RW = 5;
    localparam int CMD_RS_HI = 4;
    localparam int CMD_RS_LO = 3;
    localparam int CMD_CREAD = 2;
    localparam logic [5:0] CREAD_ENTER = 6'h0f;
    localparam logic [5:0] CREAD_EXIT = 6'h0e;
    // register select codes
    localparam logic [1:0] RS_COMM = 2'h0;
    localparam logic [1:0] RS_MODE = 2'h1;
    localparam logic [1:0] RS_DATA = 2'h3;
    // mode field position and codes
    localparam int MODE_SEL_HI = 7;
    localparam int MODE_SEL_LO = 6;
    localparam logic [1:0] MD_CONT = 2'h0;
    localparam logic [1:0] MD_SINGLE = 2'h2;
    // apb map
    localparam int APB_AW = 12;
    localparam logic [11:0] APB_STATUS = 12'h000;
    localparam logic [11:0] APB_SAMPLE = 12'h004;
    localparam logic [11:0] APB_DATA = 12'h008;

    typedef enum logic [2:0] {
        ST_CMD = 3'b001,
        ST_WR = 3'b010,
        ST_RD = 3'b100
    } asc_fsm_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [APB_AW-1:0] paddr;
        logic [31:0] pwdata;
    } asc_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } asc_apb_rsp_t;

    typedef struct packed {
        logic [2:0] cs_sy;
        logic [2:0] sck_sy;
        logic [2:0] din_sy;
        logic cs_f;
        logic sck_f;
        logic din_f;
        asc_fsm_t fsm;
        logic [4:0] bitcnt;
        logic [7:0] rx_sr;
        logic [DATA_W-1:0] tx_sr;
        logic dout;
        logic pin;
        logic out_sel;
        logic pre;
        logic rd_active;
        logic rd_data;
        logic [4:0] out_cnt;
        logic [4:0] rd_len;
        logic [7:0] mode;
        logic [1:0] chan;
        logic [DATA_W-1:0] data;
        logic [DATA_W-1:0] sample;
        logic rdy_n;
        logic cread;
        logic [5:0] ones;
        logic [23:0] timer;
        logic [1:0] conv_left;
        logic conv_run;
        logic single;
        logic upd_pend;
        logic [31:0] prdata;
        logic perr;
    } asc_state_t;
endpackage

/* verilog/asc_serial_ctrl.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - command byte picks read or write and the target register
// - ready line falls on new result, rises after data register read
// - ready rises one cycle before the data register is updated
// - data register re-readable outside continuous read; once only inside it
// - select tied low still works; status ready bit can be polled
// - select falling edge presents the msb in frame sync use
// - 32 consecutive ones on data input reset the interface
// - interface reset restores command wait and power-on register values
// - results at 16.6 Hz; settling takes two output periods
// - single mode: one two-period conversion, ready low, then shutdown
// - single mode: line stays high after read until next result
// - continuous conversion after power-up; ready low each result
// - command 001111xx enters continuous read; results shift out unprompted
// - continuous read: line high after read until next result
// - continuous read: unread or partly read word is dropped and new result loaded
// - command 001110xx while ready low leaves continuous read
// - select qualifies the device on a shared serial bus
// - mode bits 7:6: 00 continuous, 01 reserved, 10 single, 11 off
// - data register code 11 is read-only; read sets ready high
module asc_serial_ctrl #(
    parameter int unsigned PERIOD_CYC = asc_pkg::PERIOD_CYC
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // register bus
    input wire asc_pkg::asc_apb_req_t apb_req_i,
    output asc_pkg::asc_apb_rsp_t apb_rsp_o,
    // serial link
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire logic din_i,
    output logic dout_rdy_o,
    output logic dout_rdy_oe_o
);

    asc_pkg::asc_state_t s_q;
    asc_pkg::asc_state_t s_d;

    function automatic asc_pkg::asc_state_t reset_state();
        asc_pkg::asc_state_t r;
        r = '0;
        r.cs_sy = 3'h7;
        r.sck_sy = 3'h7;
        r.cs_f = 1'b1;
        r.sck_f = 1'b1;
        r.fsm = asc_pkg::ST_CMD;
        r.pin = 1'b1;
        r.mode = asc_pkg::MODE_RST;
        r.rdy_n = 1'b1;
        // continuous conversion from power-up, first result after settling
        r.conv_run = 1'b1;
        r.conv_left = 2'(asc_pkg::SETTLE_PERIODS);
        r.timer = 24'(PERIOD_CYC - 1);
        return r;
    endfunction

    // serial register contents, left justified in the shift word
    function automatic logic [asc_pkg::DATA_W-1:0] reg_word(
        input asc_pkg::asc_state_t s, input logic [1:0] rs);
        logic [7:0] b;
        b = (rs == asc_pkg::RS_MODE) ? s.mode : {s.rdy_n, 3'h0, asc_pkg::STATUS_ID};
        if (rs == asc_pkg::RS_DATA) begin
            return s.data;
        end
        return {b, (asc_pkg::DATA_W - 8)'(0)};
    endfunction

    function automatic logic [4:0] reg_len(input logic [1:0] rs);
        return (rs == asc_pkg::RS_DATA) ? 5'(asc_pkg::DATA_W) : 5'h08;
    endfunction

    always_comb begin
        logic cs_fall;
        logic cs_high;
        logic sck_rise;
        logic sck_fall;
        logic [7:0] cmd;
        logic [1:0] md;
        logic loaded;
        cs_fall = 1'b0;
        cs_high = 1'b0;
        sck_rise = 1'b0;
        sck_fall = 1'b0;
        cmd = '0;
        md = '0;
        loaded = 1'b0;
        s_d = s_q;

        // three-stage sync; a level counts once stages two and three agree
        s_d.cs_sy = {s_q.cs_sy[1:0], cs_n_i};
        s_d.sck_sy = {s_q.sck_sy[1:0], sclk_i};
        s_d.din_sy = {s_q.din_sy[1:0], din_i};
        if (s_q.cs_sy[2] == s_q.cs_sy[1]) begin
            s_d.cs_f = s_q.cs_sy[2];
        end
        if (s_q.sck_sy[2] == s_q.sck_sy[1]) begin
            s_d.sck_f = s_q.sck_sy[2];
        end
        if (s_q.din_sy[2] == s_q.din_sy[1]) begin
            s_d.din_f = s_q.din_sy[2];
        end
        cs_fall = s_q.cs_f && !s_d.cs_f;
        cs_high = s_d.cs_f;
        sck_rise = !s_q.sck_f && s_d.sck_f && !cs_high;
        sck_fall = s_q.sck_f && !s_d.sck_f && !cs_high;

        // conversion timer; reserved and power-down codes stop it
        if (s_q.conv_run) begin
            if (s_q.timer == 24'h00_0000) begin
                s_d.timer = 24'(PERIOD_CYC - 1);
                if (s_q.conv_left > 2'h1) begin
                    s_d.conv_left = s_q.conv_left - 2'h1;
                end else begin
                    // raise ready before the data register changes
                    s_d.rdy_n = 1'b1;
                    s_d.upd_pend = 1'b1;
                    s_d.conv_run = !s_q.single;
                end
            end else begin
                s_d.timer = s_q.timer - 24'h00_0001;
            end
        end
        if (s_q.upd_pend) begin
            s_d.upd_pend = 1'b0;
            // a data read in progress keeps its word; the new one is dropped
            if (!(s_q.fsm == asc_pkg::ST_RD && s_q.rd_data)) begin
                s_d.data = s_q.sample;
                s_d.rdy_n = 1'b0;
                if (s_q.cread) begin
                    loaded = 1'b1;
                    // stale or partly shifted word is discarded
                    s_d.tx_sr = s_q.sample;
                    s_d.rd_active = 1'b1;
                    s_d.rd_data = 1'b1;
                    s_d.rd_len = 5'(asc_pkg::DATA_W);
                    s_d.out_cnt = '0;
                    s_d.out_sel = 1'b0;
                    s_d.pre = 1'b0;
                end
            end
        end

        if (cs_high) begin
            // deselect abandons a partial command or read frame; a continuous-read word stays pending
            s_d.fsm = asc_pkg::ST_CMD;
            s_d.bitcnt = '0;
            s_d.out_sel = 1'b0;
            if (!s_q.cread) begin
                s_d.rd_active = 1'b0;
            end
        end else if (cs_fall && s_d.rd_active && !s_d.out_sel) begin
            // frame sync: msb appears on the select edge
            s_d.dout = s_d.tx_sr[asc_pkg::DATA_W-1];
            s_d.tx_sr = {s_d.tx_sr[asc_pkg::DATA_W-2:0], 1'b0};
            s_d.out_sel = 1'b1;
            s_d.pre = 1'b1;
        end

        if (sck_fall && s_q.rd_active) begin
            // first fall after presenting holds the msb for the next rise
            if (s_q.pre) begin
                s_d.pre = 1'b0;
            end else begin
                s_d.dout = s_d.tx_sr[asc_pkg::DATA_W-1];
                s_d.tx_sr = {s_d.tx_sr[asc_pkg::DATA_W-2:0], 1'b0};
                s_d.out_sel = 1'b1;
            end
        end

        if (sck_rise) begin
            s_d.pre = 1'b0;
            s_d.ones = s_d.din_f ? s_q.ones + 6'h01 : 6'h00;
            // a word loaded this cycle wins over the end of the old one
            if (s_q.rd_active && s_q.out_sel && !loaded) begin
                s_d.out_cnt = s_q.out_cnt + 5'h01;
                if (s_q.out_cnt == s_q.rd_len - 5'h01) begin
                    s_d.rd_active = 1'b0;
                    s_d.out_sel = 1'b0;
                    if (s_q.rd_data) begin
                        s_d.rdy_n = 1'b1;
                    end
                    if (s_q.fsm == asc_pkg::ST_RD) begin
                        s_d.fsm = asc_pkg::ST_CMD;
                    end
                end
            end
            if (s_q.fsm != asc_pkg::ST_RD) begin
                s_d.rx_sr = {s_q.rx_sr[6:0], s_d.din_f};
                s_d.bitcnt = s_q.bitcnt + 5'h01;
            end
            cmd = {s_q.rx_sr[6:0], s_d.din_f};
            md = cmd[asc_pkg::MODE_SEL_HI:asc_pkg::MODE_SEL_LO];
            if (s_q.fsm == asc_pkg::ST_CMD && s_q.bitcnt == 5'h07) begin
                s_d.bitcnt = '0;
                if (s_q.cread) begin
                    // only the exit command is honoured, and only while ready is low
                    if (cmd[7:2] == asc_pkg::CREAD_EXIT && !s_q.rdy_n) begin
                        s_d.cread = 1'b0;
                    end
                end else if (!cmd[asc_pkg::CMD_WEN]) begin
                    s_d.chan = cmd[1:0];
                    if (cmd[7:2] == asc_pkg::CREAD_ENTER) begin
                        s_d.cread = 1'b1;
                    end else if (cmd[asc_pkg::CMD_RW]) begin
                        // read: present the msb now, shift on later falls
                        s_d.fsm = asc_pkg::ST_RD;
                        s_d.tx_sr = reg_word(s_q, cmd[asc_pkg::CMD_RS_HI:asc_pkg::CMD_RS_LO]);
                        s_d.rd_len = reg_len(cmd[asc_pkg::CMD_RS_HI:asc_pkg::CMD_RS_LO]);
                        s_d.rd_data = cmd[asc_pkg::CMD_RS_HI:asc_pkg::CMD_RS_LO]
                            == asc_pkg::RS_DATA;
                        s_d.rd_active = 1'b1;
                        s_d.out_cnt = '0;
                        s_d.dout = s_d.tx_sr[asc_pkg::DATA_W-1];
                        s_d.tx_sr = {s_d.tx_sr[asc_pkg::DATA_W-2:0], 1'b0};
                        s_d.out_sel = 1'b1;
                        s_d.pre = 1'b1;
                    end else if (cmd[asc_pkg::CMD_RS_HI:asc_pkg::CMD_RS_LO]
                        == asc_pkg::RS_MODE) begin
                        s_d.fsm = asc_pkg::ST_WR;
                    end
                end
            end else if (s_q.fsm == asc_pkg::ST_WR && s_q.bitcnt == 5'h07) begin
                s_d.bitcnt = '0;
                s_d.fsm = asc_pkg::ST_CMD;
                s_d.mode = cmd;
                // a mode write selecting continuous or single restarts conversion with full settling
                s_d.conv_run = (md == asc_pkg::MD_CONT) || (md == asc_pkg::MD_SINGLE);
                s_d.single = md == asc_pkg::MD_SINGLE;
                s_d.conv_left = 2'(asc_pkg::SETTLE_PERIODS);
                s_d.timer = 24'(PERIOD_CYC - 1);
                s_d.upd_pend = 1'b0;
            end
        end

        // apb slave: zero wait, read data latched in the setup cycle
        if (apb_req_i.psel && !apb_req_i.penable) begin
            s_d.perr = 1'b0;
            case (apb_req_i.paddr)
                asc_pkg::APB_STATUS: begin
                    s_d.prdata = {16'h0000, 3'h0, s_q.cread,
                        s_q.mode[asc_pkg::MODE_SEL_HI:asc_pkg::MODE_SEL_LO],
                        s_q.rdy_n, s_q.conv_run, 5'h00, s_q.fsm};
                end
                asc_pkg::APB_SAMPLE: begin
                    s_d.prdata = 32'(s_q.sample);
                end
                asc_pkg::APB_DATA: begin
                    s_d.prdata = 32'(s_q.data);
                end
                default: begin
                    s_d.prdata = '0;
                    s_d.perr = 1'b1;
                end
            endcase
        end
        if (apb_req_i.psel && apb_req_i.penable && apb_req_i.pwrite
            && apb_req_i.paddr == asc_pkg::APB_SAMPLE) begin
            s_d.sample = apb_req_i.pwdata[asc_pkg::DATA_W-1:0];
        end

        // interface reset keeps sync stages, front-end sample and bus state
        if (s_d.ones == asc_pkg::IFRST_ONES) begin
            s_d = reset_state();
            s_d.cs_sy = {s_q.cs_sy[1:0], cs_n_i};
            s_d.sck_sy = {s_q.sck_sy[1:0], sclk_i};
            s_d.din_sy = {s_q.din_sy[1:0], din_i};
            s_d.cs_f = cs_high;
            s_d.sck_f = s_q.sck_sy[2];
            s_d.din_f = 1'b1;
            s_d.sample = s_q.sample;
            s_d.prdata = s_q.prdata;
            s_d.perr = s_q.perr;
        end

        // pin shows the shift bit while a word is out, else ready
        s_d.pin = s_d.out_sel ? s_d.dout : s_d.rdy_n;
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_q <= reset_state();
        end else begin
            s_q <= s_d;
        end
    end

    assign dout_rdy_o = s_q.pin;
    // released while deselected so the line can be shared
    assign dout_rdy_oe_o = !s_q.cs_f;
    assign apb_rsp_o.prdata = s_q.prdata;
    assign apb_rsp_o.pready = 1'b1;
    assign apb_rsp_o.pslverr = apb_req_i.psel && apb_req_i.penable && s_q.perr;

endmodule

/* verif/asc_serial_ctrl_asserts.sv */
`timescale 1ns/1ps
module asc_serial_ctrl_asserts #(
    parameter int unsigned PERIOD_CYC = asc_pkg::PERIOD_CYC
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // register bus
    input wire asc_pkg::asc_apb_req_t apb_req_i,
    input wire asc_pkg::asc_apb_rsp_t apb_rsp_o,
    // serial link
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire logic din_i,
    input wire logic dout_rdy_o,
    input wire logic dout_rdy_oe_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    logic acc;
    logic mapped;
    assign acc = apb_req_i.psel && apb_req_i.penable;
    assign mapped = apb_req_i.paddr inside {asc_pkg::APB_STATUS, asc_pkg::APB_SAMPLE,
        asc_pkg::APB_DATA};
    // select must be steady past the synchroniser before the pin follows
    sequence s_sel_low;
        !cs_n_i [*8];
    endsequence
    sequence s_sel_high;
        cs_n_i [*8];
    endsequence
    AST_PREADY: assert property (apb_req_i.psel |-> apb_rsp_o.pready)
        else $error("pready low during transfer");
    AST_ERR_MAP: assert property (acc && !mapped |->
        apb_rsp_o.pslverr && apb_rsp_o.prdata == 32'h0000_0000)
        else $error("unmapped access without error");
    AST_OK_MAP: assert property (acc && mapped |-> !apb_rsp_o.pslverr)
        else $error("error on mapped access");
    AST_ERR_ACC: assert property (apb_rsp_o.pslverr |-> acc)
        else $error("error outside access phase");
    AST_RD_HOLD: assert property (acc |=> $stable(apb_rsp_o.prdata))
        else $error("read data moved after access");
    AST_SEL_ON: assert property (s_sel_low |-> dout_rdy_oe_o)
        else $error("pin not driven while selected");
    AST_SEL_OFF: assert property (s_sel_high |-> !dout_rdy_oe_o)
        else $error("pin driven while deselected");
    AST_REL: assert property ($rose(nrst_i) |-> dout_rdy_o && !dout_rdy_oe_o)
        else $error("pin not idle after reset");
endmodule
bind asc_serial_ctrl asc_serial_ctrl_asserts #(.PERIOD_CYC(PERIOD_CYC)) i_asc_serial_ctrl_asserts (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .apb_req_i(apb_req_i), .apb_rsp_o(apb_rsp_o),
    .cs_n_i(cs_n_i), .sclk_i(sclk_i), .din_i(din_i), .dout_rdy_o(dout_rdy_o),
    .dout_rdy_oe_o(dout_rdy_oe_o));

/* verif/asc_host_model.sv */
`timescale 1ns/1ps
module asc_host_model (
    // clock
    input wire logic sys_clk_i,
    // serial link
    input wire logic dout_rdy_i,
    input wire logic dout_rdy_oe_i,
    output logic cs_n_o,
    output logic sclk_o,
    output logic din_o
);
    logic line;
    // pull-up holds the line high while the device is off it
    assign line = dout_rdy_oe_i ? dout_rdy_i : 1'b1;
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b1;
        din_o = 1'b0;
    end
    task automatic sel(input logic v);
        @(posedge sys_clk_i);
        cs_n_o <= v;
        din_o <= 1'b0;
    endtask
    // one link clock is 7 system clocks; read mid high phase, clear of both edges
    task automatic bitx(input logic b, output logic r);
        @(posedge sys_clk_i);
        sclk_o <= 1'b0;
        din_o <= b;
        repeat (4) @(posedge sys_clk_i);
        sclk_o <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        r = line;
    endtask
endmodule

/* verif/asc_serial_ctrl_test.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, gt) \
    begin \
        total_checks++; \
        if ((gt) !== (ex)) begin \
            n_errors++; \
            $display("[ERR] %s exp %0h got %0h", nm, ex, gt); \
        end \
    end
module asc_serial_ctrl_test;
    localparam int unsigned PER = 1000;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    asc_pkg::asc_apb_req_t req = '0;
    asc_pkg::asc_apb_rsp_t rsp;
    logic cs_n, sclk, din, pin, oe;
    int n_errors = 0;
    int total_checks = 0;
    int cyc = 0;
    always #25 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    asc_serial_ctrl #(.PERIOD_CYC(PER)) i_asc_serial_ctrl (.sys_clk_i(clk), .nrst_i(nrst),
        .apb_req_i(req), .apb_rsp_o(rsp), .cs_n_i(cs_n), .sclk_i(sclk), .din_i(din),
        .dout_rdy_o(pin), .dout_rdy_oe_o(oe));
    asc_host_model i_asc_host_model (.sys_clk_i(clk), .dout_rdy_i(pin), .dout_rdy_oe_i(oe),
        .cs_n_o(cs_n), .sclk_o(sclk), .din_o(din));
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
        output logic [31:0] rd, output logic e);
        @(posedge clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
        @(posedge clk);
        req.penable <= 1'b1;
        do @(posedge clk); while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        e = rsp.pslverr;
        req <= '0;
    endtask
    task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
        logic r;
        rx = '0;
        for (int i = n - 1; i >= 0; i--) begin
            i_asc_host_model.bitx(tx[i], r);
            rx = {rx[30:0], r};
        end
        i_asc_host_model.sel(1'b0);
        repeat (2) @(posedge clk);
    endtask
    task automatic wait_rdy(input int lim, output int t);
        int i;
        i = 0;
        while (pin !== 1'b0 && i < lim) begin
            @(posedge clk);
            i++;
        end
        `CHK("ready", 1'b0, pin)
        t = cyc;
    endtask
    task automatic t_cont();
        logic [31:0] rx, rd;
        logic e;
        int t0, t1;
        apb(1'b1, asc_pkg::APB_SAMPLE, 32'h00A5_C3F0, rd, e);
        i_asc_host_model.sel(1'b0);
        apb(1'b0, asc_pkg::APB_STATUS, '0, rd, e);
        `CHK("mode", asc_pkg::MD_CONT, rd[11:10])
        wait_rdy(2 * PER + 20, t0);
        `CHK("settle", 1'b1, t0 >= 2 * PER && t0 <= 2 * PER + 20)
        // all reads end well before the next result is due
        xfer(32'h3800_0000, 32, rx);
        `CHK("data", 24'hA5_C3F0, rx[23:0])
        `CHK("rdy read", 1'b1, pin)
        xfer(32'h3800_0000, 32, rx);
        `CHK("reread", 24'hA5_C3F0, rx[23:0])
        apb(1'b0, asc_pkg::APB_DATA, '0, rd, e);
        `CHK("bus data", 24'hA5_C3F0, rd[23:0])
        xfer(32'h0000_2000, 16, rx);
        `CHK("status", {1'b1, 3'b000, asc_pkg::STATUS_ID}, rx[7:0])
        wait_rdy(PER, t1);
        `CHK("period", PER, t1 - t0)
        t0 = 0;
        while (pin !== 1'b1 && t0 < PER + 8) begin
            @(posedge clk);
            t0++;
        end
        @(posedge clk);
        `CHK("blip", 2'b10, {t0 < PER + 8, pin})
    endtask
    task automatic t_single();
        logic [31:0] rx, rd;
        logic e;
        int t0, t1;
        apb(1'b1, asc_pkg::APB_SAMPLE, 32'h005A_0F1E, rd, e);
        xfer(32'h3800_0000, 32, rx);
        xfer(32'h0000_0882, 16, rx);
        t0 = cyc;
        apb(1'b0, asc_pkg::APB_STATUS, '0, rd, e);
        `CHK("single", asc_pkg::MD_SINGLE, rd[11:10])
        wait_rdy(2 * PER + 12, t1);
        `CHK("conv time", 1'b1, t1 - t0 > 2 * PER - 20)
        xfer(32'h3800_0000, 32, rx);
        `CHK("single data", 24'h5A_0F1E, rx[23:0])
        e = 1'b0;
        repeat (3 * PER) begin
            @(posedge clk);
            e = e | !pin;
        end
        `CHK("idle", 1'b0, e)
        xfer(32'h3800_0000, 32, rx);
        `CHK("reread", 24'h5A_0F1E, rx[23:0])
        xfer(32'hFFFF_FFFF, 32, rx);
        apb(1'b0, asc_pkg::APB_STATUS, '0, rd, e);
        `CHK("ifrst", 6'b000_001, {rd[12:10], rd[2:0]})
        xfer(32'h0000_2800, 16, rx);
        `CHK("mode rst", asc_pkg::MODE_RST, rx[7:0])
    endtask
    task automatic t_cread();
        logic [31:0] rx, rd;
        logic e;
        int t0;
        apb(1'b1, asc_pkg::APB_SAMPLE, 32'h0081_2345, rd, e);
        xfer(32'h0000_003C, 8, rx);
        wait_rdy(2 * PER + 40, t0);
        xfer(32'h0, 24, rx);
        `CHK("cread", 24'h81_2345, rx[23:0])
        `CHK("cread high", 1'b1, pin)
        wait_rdy(PER + 8, t0);
        apb(1'b1, asc_pkg::APB_SAMPLE, 32'h0065_4321, rd, e);
        repeat (PER) @(posedge clk);
        wait_rdy(8, t0);
        xfer(32'h0, 24, rx);
        `CHK("reload", 24'h65_4321, rx[23:0])
        apb(1'b1, asc_pkg::APB_SAMPLE, 32'h0081_2345, rd, e);
        i_asc_host_model.sel(1'b1);
        repeat (8) @(posedge clk);
        `CHK("oe off", 1'b0, oe)
        rd = 32'hFFFF_FFFF;
        for (int i = 0; i < PER && rd[9] !== 1'b0; i++) begin
            apb(1'b0, asc_pkg::APB_STATUS, '0, rd, e);
        end
        i_asc_host_model.sel(1'b0);
        repeat (8) @(posedge clk);
        `CHK("sel msb", 2'b11, {oe, pin})
        xfer(32'h0000_0038, 8, rx);
        apb(1'b0, asc_pkg::APB_STATUS, '0, rd, e);
        `CHK("exit", 1'b0, rd[12])
        apb(1'b0, 12'h00C, '0, rd, e);
        `CHK("unmapped", 33'h1_0000_0000, {e, rd})
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        t_cont();
        t_single();
        t_cread();
        give_verdict();
    end
    // whole run needs some 15000 cycles
    initial begin
        repeat (60000) @(posedge clk);
        n_errors++;
        give_verdict();
    end
endmodule
